// [design/flash_read_param_regs.sv]
// Read-parameter and extended read register logic of a serial flash.
//
// Behaviour
// - Wrap off: sequential reads run linearly.
// - Wrap on: addresses wrap inside burst.
// - Nonzero dummy field sets the dummy count.
// - Serial fast read defaults to eight.
// - Four-lane fast read defaults to six.
// - Dual output read defaults to eight.
// - Dual I/O read defaults to four.
// - Quad output read defaults to eight.
// - Quad I/O read defaults to six.
// - Unique-id and info-row reads follow fast read.
// - Dual I/O double-rate refused in four-lane mode.
// - Extended bits seven to five select drive.
// - Extended bits three to zero are read-only.
// - Set commands never change read-only bits.
// - Extended bit four is reserved.
// - 85h writes persistent, 83h volatile copy.
// - Extended register resets to ones above zeros.
// - Power-up copies persistent into volatile registers.
// - Burst code gives 8, 16, 32, 64 bytes.
// - Error flags stay until cleared.
// - Extended bit zero mirrors busy.
`timescale 1ns/100ps

module flash_read_param_regs #(
    parameter int ADDR_W = 24,
    parameter logic [7:0] OP_READ_UNIQUE_ID = 8'h4b,
    parameter logic [7:0] OP_INFO_ROW_READ = 8'h68,
    parameter logic [7:0] OP_CLEAR_ERRORS = 8'h82
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] link_io,
    input wire logic four_lane_cmd_mode,
    input wire logic write_busy_flag,
    input wire logic protect_violation_set,
    input wire logic program_error_set,
    input wire logic erase_error_set,
    input wire logic soft_reset,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [7:0] read_params_reg,
    output logic [7:0] read_params_nv_reg,
    output logic [7:0] ext_params_reg,
    output logic [7:0] ext_params_nv_reg,
    output logic [2:0] drive_strength_reg,
    output logic [3:0] dummy_cycles_reg,
    output logic read_start_reg,
    output logic read_reject_reg,
    output logic [ADDR_W-1:0] rd_addr_next_reg
);
    import flash_param_pkg::*;

    // The wrap logic needs room for the longest burst of 64 bytes.
    if (ADDR_W < 7) begin : g_bad_width
        $error("ADDR_W must be at least 7");
    end

    // Every flip-flop of the block lives in this one record.
    typedef struct packed {
        phase_t phase;              // Frame phase.
        logic sck_m;                // Serial clock, first sync stage.
        logic sck_s;                // Serial clock, second sync stage.
        logic sck_p;                // Previous synced serial clock.
        logic csn_m;                // Chip select, first sync stage.
        logic csn_s;                // Chip select, second sync stage.
        logic [3:0] io_m;           // Data lanes, first sync stage.
        logic [3:0] io_s;           // Data lanes, second sync stage.
        logic [7:0] shift;          // Incoming byte.
        logic [3:0] bits;           // Bits gathered so far.
        logic [7:0] opcode;         // Opcode of the current frame.
        logic [7:0] rd_nv;          // Persistent read register copy.
        logic [7:0] rd_v;           // Volatile read register copy.
        logic [7:0] ext_nv;         // Persistent extended copy.
        logic [7:0] ext_v;          // Volatile extended copy.
        logic [2:0] err;            // Erase, program, protect flags.
        logic pend_clear;           // Clear command seen last cycle.
        logic [3:0] dummy;          // Dummy count of the last read.
        logic rd_start;             // One-cycle read accepted pulse.
        logic rd_reject;            // One-cycle read refused pulse.
        logic [ADDR_W-1:0] addr_next; // Next sequential read address.
    } state_t;

    state_t st_reg;   // Registered state.
    state_t st_next;  // Next state.

    // Next sequential address; wraps inside an aligned burst when enabled.
    function automatic logic [ADDR_W-1:0] wrap_next(
        input logic [ADDR_W-1:0] addr,
        input logic wrap_on,
        input logic [1:0] len_code
    );
        logic [ADDR_W-1:0] mask;
        logic [ADDR_W-1:0] inc;
        mask = ADDR_W'((WRAP_BASE_BYTES << len_code) - 1);
        inc = ADDR_W'(addr + 1'b1);
        if (wrap_on) begin
            return (addr & ~mask) | (inc & mask);
        end
        return inc;
    endfunction : wrap_next

    // Dummy count for a read opcode: {known, count}. Dual and quad output
    // reads and both dual I/O reads are serial-only commands, so four-lane mode does not know them.
    function automatic logic [4:0] read_dummy(
        input logic [7:0] op,
        input logic quad,
        input logic [3:0] field
    );
        logic known;
        logic [3:0] dflt;
        known = 1'b1;
        dflt = 4'h0;
        if (op == OP_FAST_READ || op == OP_FAST_READ_DR
            || op == OP_READ_UNIQUE_ID || op == OP_INFO_ROW_READ) begin
            // Id and info-row reads borrow the fast read count.
            dflt = quad ? DUMMY_FOUR_LANE_FAST : DUMMY_SERIAL_FAST;
        end else if (op == OP_QUAD_IO || op == OP_QUAD_IO_DR) begin
            dflt = DUMMY_QUAD_IO;
        end else if (!quad && op == OP_DUAL_OUT) begin
            dflt = DUMMY_DUAL_OUT;
        end else if (!quad && (op == OP_DUAL_IO || op == OP_DUAL_IO_DR)) begin
            dflt = DUMMY_DUAL_IO;
        end else if (!quad && op == OP_QUAD_OUT) begin
            dflt = DUMMY_QUAD_OUT;
        end else begin
            known = 1'b0;
        end
        // A nonzero field overrides every default.
        return {known, (field != 4'h0) ? field : dflt};
    endfunction : read_dummy

    // Next-state logic for synchronisers, frame decoder and registers.
    always_comb begin
        logic sck_rise;
        logic [7:0] shifted;
        logic [3:0] cnt;
        logic [4:0] dres;
        sck_rise = st_reg.sck_s & ~st_reg.sck_p;
        shifted = 8'h00;
        cnt = 4'h0;
        dres = 5'h00;
        st_next = st_reg;

        // Two-stage synchronisers; only the second stage is used below.
        st_next.sck_m = sck;
        st_next.sck_s = st_reg.sck_m;
        st_next.sck_p = st_reg.sck_s;
        st_next.csn_m = cs_n;
        st_next.csn_s = st_reg.csn_m;
        st_next.io_m = link_io;
        st_next.io_s = st_reg.io_m;

        // Pulses last one cycle only.
        st_next.rd_start = 1'b0;
        st_next.rd_reject = 1'b0;
        st_next.pend_clear = 1'b0;

        // Error flags are sticky; a new error beats a same-cycle clear.
        st_next.err = (st_reg.err & ~{3{st_reg.pend_clear | soft_reset}})
            | {erase_error_set, program_error_set,
               protect_violation_set};

        // Low nibble reports hardware state only, never written data.
        st_next.ext_v[ERASE_BIT:PROT_BIT] = st_reg.err;
        st_next.ext_v[BUSY_BIT] = write_busy_flag;
        st_next.ext_v[EXT_RESERVED_BIT] = 1'b1;

        st_next.addr_next = wrap_next(rd_addr, st_reg.rd_v[WRAP_SEL_BIT],
            st_reg.rd_v[BURST_LEN_LSB +: 2]);

        // Shift one lane, or four lanes in four-lane command mode.
        if (four_lane_cmd_mode) begin
            shifted = {st_reg.shift[3:0], st_reg.io_s};
            cnt = st_reg.bits + 4'h4;
        end else begin
            shifted = {st_reg.shift[6:0], st_reg.io_s[0]};
            cnt = st_reg.bits + 4'h1;
        end

        case (st_reg.phase)
            PH_LOAD: begin
                // Volatile copies take the persistent values first.
                st_next.rd_v = st_reg.rd_nv;
                st_next.ext_v[7:DRIVE_LSB] = st_reg.ext_nv[7:DRIVE_LSB];
                st_next.phase = PH_OPCODE;
                st_next.bits = 4'h0;
            end
            default: begin
                if (st_reg.csn_s) begin
                    // Deselect ends any frame, complete or not.
                    st_next.phase = PH_OPCODE;
                    st_next.bits = 4'h0;
                end else if (sck_rise && st_reg.phase != PH_SKIP) begin
                    st_next.shift = shifted;
                    st_next.bits = cnt;
                    if (cnt >= BITS_PER_BYTE) begin
                        st_next.bits = 4'h0;
                        st_next.phase = PH_SKIP;
                        if (st_reg.phase == PH_OPCODE) begin
                            st_next.opcode = shifted;
                            dres = read_dummy(shifted, four_lane_cmd_mode,
                                st_reg.rd_v[DUMMY_LSB +: 4]);
                            if (shifted == OP_SET_READ_NV
                                || shifted == OP_SET_READ_V
                                || shifted == OP_SET_READ_V_ALT
                                || shifted == OP_SET_EXT_NV
                                || shifted == OP_SET_EXT_V) begin
                                st_next.phase = PH_DATA;
                            end else if (shifted == OP_CLEAR_ERRORS) begin
                                st_next.pend_clear = 1'b1;
                            end else if (four_lane_cmd_mode
                                && shifted == OP_DUAL_IO_DR) begin
                                st_next.rd_reject = 1'b1;
                            end else if (dres[4]) begin
                                st_next.rd_start = 1'b1;
                                st_next.dummy = dres[3:0];
                            end
                        end else begin
                            // Data byte of a set command.
                            if (st_reg.opcode == OP_SET_READ_NV) begin
                                st_next.rd_nv = shifted;
                            end else if (st_reg.opcode == OP_SET_EXT_NV) begin
                                // Only the drive field is stored.
                                st_next.ext_nv[7:DRIVE_LSB] =
                                    shifted[7:DRIVE_LSB];
                            end else if (st_reg.opcode == OP_SET_EXT_V) begin
                                st_next.ext_v[7:DRIVE_LSB] =
                                    shifted[7:DRIVE_LSB];
                            end else begin
                                st_next.rd_v = shifted;
                            end
                        end
                    end
                end
            end
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.phase <= PH_LOAD;
            st_reg.sck_m <= 1'b0;
            st_reg.csn_m <= 1'b1;
            st_reg.csn_s <= 1'b1;
            st_reg.rd_nv <= READ_PARAMS_RESET;
            st_reg.rd_v <= READ_PARAMS_RESET;
            st_reg.ext_nv <= EXT_PARAMS_RESET;
            st_reg.ext_v <= EXT_PARAMS_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs are plain taps of the state record.
    assign read_params_reg = st_reg.rd_v;
    assign read_params_nv_reg = st_reg.rd_nv;
    assign ext_params_reg = st_reg.ext_v;
    assign ext_params_nv_reg = st_reg.ext_nv;
    assign drive_strength_reg = st_reg.ext_v[7:DRIVE_LSB];
    assign dummy_cycles_reg = st_reg.dummy;
    assign read_start_reg = st_reg.rd_start;
    assign read_reject_reg = st_reg.rd_reject;
    assign rd_addr_next_reg = st_reg.addr_next;

    // Checks on the registered behaviour.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_wrap_off_linear: assert property (
        !st_reg.rd_v[WRAP_SEL_BIT] |=>
            rd_addr_next_reg == ADDR_W'($past(rd_addr) + 1'b1))
        else $error("linear read address did not advance by one");

    a_wrap_on_block: assert property (
        st_reg.rd_v[WRAP_SEL_BIT] |=>
            (rd_addr_next_reg >> 6) == ($past(rd_addr) >> 6))
        else $error("wrapped address left its burst block");

    a_dummy_field_used: assert property (
        read_start_reg && st_reg.rd_v[DUMMY_LSB +: 4] != 4'h0 |->
            dummy_cycles_reg == st_reg.rd_v[DUMMY_LSB +: 4])
        else $error("dummy count differs from programmed field");

    a_serial_fast_dflt: assert property (
        read_start_reg && st_reg.rd_v[DUMMY_LSB +: 4] == 4'h0
        && !$past(four_lane_cmd_mode)
        && (st_reg.opcode == OP_FAST_READ
            || st_reg.opcode == OP_FAST_READ_DR) |->
            dummy_cycles_reg == DUMMY_SERIAL_FAST)
        else $error("serial fast read default is not eight");

    a_dual_io_dflt: assert property (
        read_start_reg && st_reg.rd_v[DUMMY_LSB +: 4] == 4'h0
        && st_reg.opcode == OP_DUAL_IO |-> dummy_cycles_reg == DUMMY_DUAL_IO)
        else $error("dual io default is not four");

    a_quad_io_dflt: assert property (
        read_start_reg && st_reg.rd_v[DUMMY_LSB +: 4] == 4'h0
        && st_reg.opcode == OP_QUAD_IO |-> dummy_cycles_reg == DUMMY_QUAD_IO)
        else $error("quad io default is not six");

    a_dual_dr_refused: assert property (
        st_reg.opcode == OP_DUAL_IO_DR && $changed(st_reg.opcode)
        && $past(four_lane_cmd_mode) |-> read_reject_reg && !read_start_reg)
        else $error("dual io double-rate accepted in four-lane mode");

    a_reserved_one: assert property (
        st_reg.phase != PH_LOAD |-> ##1 ext_params_reg[EXT_RESERVED_BIT])
        else $error("reserved extended bit is not one");

    a_busy_mirror: assert property (
        st_reg.phase != PH_LOAD |=>
            ext_params_reg[BUSY_BIT] == $past(write_busy_flag))
        else $error("busy bit does not follow busy input");

    // The flag may only fall after a clear seen in the cycle before.
    a_error_sticky: assert property (
        protect_violation_set |=> st_reg.err[0] ##1 (st_reg.err[0]
            || $past(st_reg.pend_clear) || $past(soft_reset)))
        else $error("protect error flag dropped without a clear");

    a_four_lane_dflt: assert property (
        read_start_reg && st_reg.rd_v[DUMMY_LSB +: 4] == 4'h0
        && $past(four_lane_cmd_mode)
        && (st_reg.opcode == OP_FAST_READ
            || st_reg.opcode == OP_FAST_READ_DR) |->
            dummy_cycles_reg == DUMMY_FOUR_LANE_FAST)
        else $error("four-lane fast read default is not six");

    // Id reads are held to the fast read default of their lane mode.
    a_id_read_dflt: assert property (
        read_start_reg && st_reg.rd_v[DUMMY_LSB +: 4] == 4'h0
        && (st_reg.opcode == OP_READ_UNIQUE_ID
            || st_reg.opcode == OP_INFO_ROW_READ) |->
            dummy_cycles_reg == ($past(four_lane_cmd_mode)
                ? DUMMY_FOUR_LANE_FAST : DUMMY_SERIAL_FAST))
        else $error("id read default differs from fast read");

    // Written data never reaches the status bits; only the flags do.
    a_status_readonly: assert property (
        st_reg.phase != PH_LOAD |=>
            ext_params_reg[ERASE_BIT:PROT_BIT] == $past(st_reg.err))
        else $error("status bits differ from the error flags");

    a_load_copy: assert property (
        st_reg.phase == PH_LOAD |=>
            read_params_reg == $past(read_params_nv_reg)
            && drive_strength_reg == $past(ext_params_nv_reg[7:DRIVE_LSB]))
        else $error("volatile copy not loaded from persistent copy");

    c_read_start: cover property (read_start_reg);
    c_read_reject: cover property (read_reject_reg);
    c_ext_write: cover property ($changed(drive_strength_reg));
    c_error_clear: cover property (st_reg.pend_clear && st_reg.err != 3'h0);

endmodule : flash_read_param_regs

// [inc/flash_param_pkg.sv]
// Shared constants and types for the flash read-parameter register block.
package flash_param_pkg;

    // Opcodes that write the read register.
    localparam logic [7:0] OP_SET_READ_NV = 8'h65;
    localparam logic [7:0] OP_SET_READ_V = 8'hc0;
    localparam logic [7:0] OP_SET_READ_V_ALT = 8'h63;
    // Opcodes that write the extended read register.
    localparam logic [7:0] OP_SET_EXT_NV = 8'h85;
    localparam logic [7:0] OP_SET_EXT_V = 8'h83;

    // Fast read family opcodes.
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_FAST_READ_DR = 8'h0d;
    localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
    localparam logic [7:0] OP_DUAL_IO = 8'hbb;
    localparam logic [7:0] OP_DUAL_IO_DR = 8'hbd;
    localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
    localparam logic [7:0] OP_QUAD_IO = 8'heb;
    localparam logic [7:0] OP_QUAD_IO_DR = 8'hed;

    // Reset values of both register copies.
    localparam logic [7:0] READ_PARAMS_RESET = 8'h00;
    localparam logic [7:0] EXT_PARAMS_RESET = 8'hf0;

    // Field positions in the read register.
    localparam int BURST_LEN_LSB = 0;
    localparam int WRAP_SEL_BIT = 2;
    localparam int DUMMY_LSB = 3;

    // Field positions in the extended read register.
    localparam int BUSY_BIT = 0;
    localparam int PROT_BIT = 1;
    localparam int PROG_BIT = 2;
    localparam int ERASE_BIT = 3;
    localparam int EXT_RESERVED_BIT = 4;
    localparam int DRIVE_LSB = 5;

    // Default dummy counts used when the dummy field is zero.
    localparam logic [3:0] DUMMY_SERIAL_FAST = 4'h8;
    localparam logic [3:0] DUMMY_FOUR_LANE_FAST = 4'h6;
    localparam logic [3:0] DUMMY_DUAL_OUT = 4'h8;
    localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
    localparam logic [3:0] DUMMY_QUAD_OUT = 4'h8;
    localparam logic [3:0] DUMMY_QUAD_IO = 4'h6;

    // Shortest wrap burst in bytes; longer codes double it.
    localparam int WRAP_BASE_BYTES = 8;
    // Bits in one command or data byte.
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Phases of a command frame on the link.
    typedef enum logic [1:0] {
        PH_LOAD,
        PH_OPCODE,
        PH_DATA,
        PH_SKIP
    } phase_t;

endpackage : flash_param_pkg

// [testbench/flash_host_model.sv]
// Host controller model that drives command frames onto the link.
`timescale 1ns/100ps

module flash_host_model (
    input wire logic ref_clk,
    output logic sck,
    output logic cs_n,
    output logic [3:0] link_io
);
    // The link starts idle: clock parked low, chip deselected.
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        link_io = 4'h0;
    end

    // Shifts a byte MSB first; each sck half period is four ref_clk cycles.
    task automatic put_byte(input logic [7:0] b, input logic quad);
        for (int i = 0; i < (quad ? 2 : 8); i++) begin
            // Idle lanes carry the inverse bit so a wrong lane never matches.
            link_io <= quad ? b[7-4*i -: 4] : {{3{~b[7-i]}}, b[7-i]};
            repeat (4) @(posedge ref_clk);
            sck <= 1'b1;
            repeat (4) @(posedge ref_clk);
            sck <= 1'b0;
        end
    endtask : put_byte

    // One frame; the opcode alone picks the register copy written.
    task automatic frame(
        input logic [7:0] op,
        input logic has_d,
        input logic [7:0] d,
        input logic quad
    );
        @(posedge ref_clk);
        cs_n <= 1'b0;
        put_byte(op, quad);
        if (has_d) begin
            put_byte(d, quad);
        end
        // Lanes are still driven after the last byte, but with the inverse value, and no sck edge
        // follows, so the dummy cycles of a read never shift in the host's last data.
        link_io <= ~link_io;
        repeat (8) @(posedge ref_clk);
        cs_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
    endtask : frame
endmodule : flash_host_model

// [testbench/tb_flash_read_param_regs.sv]
// Self-checking bench for the flash read-parameter register block.
`timescale 1ns/100ps

module tb_flash_read_param_regs;
    import flash_param_pkg::*;
    // Opcode values picked for the parameterised commands.
    localparam logic [7:0] UID_OP = 8'h4b;
    localparam logic [7:0] ROW_OP = 8'h68;
    localparam logic [7:0] CLR_OP = 8'h82;
    localparam logic [7:0] OPS [10] = '{8'h0b, 8'h0d, 8'h3b, 8'hbb,
        8'hbd, 8'h6b, 8'heb, 8'hed, UID_OP, ROW_OP};
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sck, cs_n, rd_start, rd_rej;
    logic [3:0] link_io, dummy;
    logic four_lane_cmd_mode = 1'b0;
    logic write_busy_flag = 1'b0;
    logic prot_set = 1'b0;
    logic prog_set = 1'b0;
    logic erase_set = 1'b0;
    logic soft_reset = 1'b0;
    logic [23:0] rd_addr = 24'h0;
    logic [23:0] nxt;
    logic [7:0] rp, rp_nv, ep, ep_nv;
    logic [2:0] drv;
    int err_count = 0;
    int comparisons = 0;
    int starts, rejects;

    always #20 ref_clk = ~ref_clk;

    flash_host_model host (.ref_clk(ref_clk), .sck(sck), .cs_n(cs_n),
        .link_io(link_io));

    flash_read_param_regs #(.ADDR_W(24), .OP_READ_UNIQUE_ID(UID_OP),
        .OP_INFO_ROW_READ(ROW_OP), .OP_CLEAR_ERRORS(CLR_OP)) DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n),
        .link_io(link_io), .four_lane_cmd_mode(four_lane_cmd_mode),
        .write_busy_flag(write_busy_flag), .protect_violation_set(prot_set),
        .program_error_set(prog_set), .erase_error_set(erase_set),
        .soft_reset(soft_reset), .rd_addr(rd_addr),
        .read_params_reg(rp), .read_params_nv_reg(rp_nv),
        .ext_params_reg(ep), .ext_params_nv_reg(ep_nv),
        .drive_strength_reg(drv), .dummy_cycles_reg(dummy),
        .read_start_reg(rd_start), .read_reject_reg(rd_rej),
        .rd_addr_next_reg(nxt));

    // Pulses are one cycle wide, so they are counted at every edge.
    always @(posedge ref_clk) begin
        if (rd_start === 1'b1) starts++;
        if (rd_rej === 1'b1) rejects++;
    end

    // Default dummy count per opcode and lane mode.
    function automatic logic [3:0] exp_dummy(logic [7:0] op, logic q);
        case (op)
            8'hbb, 8'hbd: return 4'h4;
            8'h3b, 8'h6b: return 4'h8;
            8'heb, 8'hed: return 4'h6;
            default: return q ? 4'h6 : 4'h8;
        endcase
    endfunction : exp_dummy

    // Next sequential address, wrapping inside an aligned burst.
    function automatic logic [23:0] exp_next(logic [23:0] a, logic w,
        logic [1:0] l);
        logic [23:0] m;
        m = (24'h8 << l) - 24'h1;
        return w ? ((a & ~m) | ((a + 24'h1) & m)) : a + 24'h1;
    endfunction : exp_next

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : settle

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Raises the chosen error set pulses for one cycle.
    task automatic set_errs(input logic [2:0] e);
        prot_set <= e[0];
        prog_set <= e[1];
        erase_set <= e[2];
        settle(1);
        prot_set <= 1'b0;
        prog_set <= 1'b0;
        erase_set <= 1'b0;
        settle(4);
    endtask : set_errs

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // A hang counts as a mismatch and ends the run.
    initial begin
        settle(60000);
        err_count++;
        finish_test();
    end

    initial begin
        logic [7:0] d;
        logic [3:0] hold;
        logic [23:0] a;
        logic ok;
        void'($urandom(40082));
        hold = 4'h0;
        settle(12);
        sys_rst <= 1'b0;
        settle(6);
        check(rp, 8'h00);
        check(ep, 8'hf0);
        check(drv, 3'h7);
        // Volatile extended writes keep the status nibble and bit four.
        for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 8'h0f : 8'($urandom);
            host.frame(OP_SET_EXT_V, 1'b1, d, 1'b0);
            check(ep, {d[7:5], 5'h10});
            check(drv, d[7:5]);
            check(ep_nv, 8'hf0);
        end
        d = 8'($urandom);
        host.frame(OP_SET_EXT_NV, 1'b1, d, 1'b0);
        check(ep_nv, {d[7:5], 5'h10});
        host.frame(OP_SET_READ_NV, 1'b1, d, 1'b0);
        check(rp_nv[6:0], d[6:0]);
        check(rp, 8'h00);
        // Every read opcode in both lane modes with the field at zero.
        for (int q = 0; q < 2; q++) begin
            four_lane_cmd_mode <= q[0];
            settle(2);
            for (int i = 0; i < 10; i++) begin
                starts = 0;
                rejects = 0;
                host.frame(OPS[i], 1'b0, 8'h00, q[0]);
                ok = !(q[0] && OPS[i] inside {8'h3b, 8'hbb, 8'h6b, 8'hbd});
                if (ok) hold = exp_dummy(OPS[i], q[0]);
                check(24'(starts), {23'h0, ok});
                check(24'(rejects), 24'(q[0] && OPS[i] == 8'hbd));
                check(dummy, hold);
            end
        end
        four_lane_cmd_mode <= 1'b0;
        // Nonzero field overrides defaults, boundaries 1 and 15 included.
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            d[6:3] = (k == 0) ? 4'h1 : (k == 3) ? 4'hf : d[6:3] | 4'h2;
            host.frame(k[0] ? OP_SET_READ_V_ALT : OP_SET_READ_V, 1'b1, d,
                1'b0);
            check(rp[6:0], d[6:0]);
            host.frame(OPS[k*2], 1'b0, 8'h00, 1'b0);
            check(dummy, d[6:3]);
        end
        // Wrap off and every burst length, some at the block's last byte.
        for (int k = 0; k < 8; k++) begin
            host.frame(OP_SET_READ_V, 1'b1, {5'h06, k[2:0]}, 1'b0);
            a = 24'($urandom);
            if (k[0]) a[5:0] = 6'h3f;
            rd_addr <= a;
            settle(3);
            check(nxt, exp_next(a, k[2], k[1:0]));
        end
        // Error flags set, survive a set command, then clear.
        set_errs(3'b001);
        check(ep[3:0], 4'h2);
        set_errs(3'b110);
        write_busy_flag <= 1'b1;
        settle(4);
        check(ep[3:0], 4'hf);
        host.frame(OP_SET_EXT_V, 1'b1, 8'h00, 1'b0);
        check(ep, 8'h1f);
        write_busy_flag <= 1'b0;
        host.frame(CLR_OP, 1'b0, 8'h00, 1'b0);
        check(ep[3:0], 4'h0);
        set_errs(3'b100);
        check(ep[3:0], 4'h8);
        soft_reset <= 1'b1;
        settle(1);
        soft_reset <= 1'b0;
        settle(4);
        check(ep[3:0], 4'h0);
        // An error raised in the very cycle of a clear survives it.
        soft_reset <= 1'b1;
        prot_set <= 1'b1;
        settle(1);
        soft_reset <= 1'b0;
        prot_set <= 1'b0;
        settle(4);
        check(ep[3:0], 4'h2);
        // A second reset in mid-run restores the defaults.
        sys_rst <= 1'b1;
        settle(2);
        sys_rst <= 1'b0;
        settle(6);
        check(ep, 8'hf0);
        check(rp, 8'h00);
        finish_test();
    end
endmodule : tb_flash_read_param_regs
